/* File: common/fwd_consts.svh */
// constants for the firmware download command block
// What this block does
// - opcode 92h selects firmware download
// - feature 03h offsets, 07h whole image
// - length: high byte, then low byte
// - zero length means no data phase
// - bad subcommand or locked drive aborts
// - failed requested reload sets uncorrectable flag
// - successful reload with spin-up disabled spins down
// - offset from cylinder regs, 512-byte units
// - offset regs used only for 03h
// - offset mismatch aborts, drops received image
// - last segment: verify, then save image
// - new firmware active after a last segment that passes verify, unless a requested reload fails
// - other command discards partial download
// - reset discards partial download
`ifndef FWD_CONSTS_SVH
`define FWD_CONSTS_SVH

`define FWD_OP_DOWNLOAD     8'h92
`define FWD_SUB_OFFSET      8'h03
`define FWD_SUB_WHOLE       8'h07

`define FWD_REG_SUBCMD      3'h1
`define FWD_REG_LEN_LO      3'h2
`define FWD_REG_LEN_HI      3'h3
`define FWD_REG_OFF_LO      3'h4
`define FWD_REG_OFF_HI      3'h5
`define FWD_REG_DRIVE       3'h6
`define FWD_REG_OPCODE      3'h7

`define FWD_ERR_UNCORR_BIT  6
`define FWD_ERR_ABORT_BIT   2
`define FWD_ST_BSY_BIT      7
`define FWD_ST_RDY_BIT      6
`define FWD_ST_DSC_BIT      4
`define FWD_ST_DRQ_BIT      3
`define FWD_ST_ERR_BIT      0

`define FWD_STATUS_RESET    8'h50
`define FWD_BYTE_ZERO       8'h00
`define FWD_SECTOR_WORD_LOG 8

`endif

/* File: common/fwd_pkg.sv */
// types shared by the firmware download command block
package fwd_pkg;

    typedef enum logic [5:0] {
        FWD_IDLE    = 6'b00_0001,
        FWD_CHECK   = 6'b00_0010,
        FWD_XFER    = 6'b00_0100,
        FWD_VERIFY  = 6'b00_1000,
        FWD_FINISH  = 6'b01_0000,
        FWD_ABORT   = 6'b10_0000
    } fwd_state_e;

    typedef logic [15:0] fwd_sectors_t;

endpackage : fwd_pkg

/* File: common/fwd_seg_if.sv */
// carrier between command control and the segment tracker
`timescale 1ns/100ps
`default_nettype none

interface fwd_seg_if;
    logic                 offset_mode;
    fwd_pkg::fwd_sectors_t seg_offset;
    fwd_pkg::fwd_sectors_t seg_count;
    logic                 offset_ok;
    logic                 last_seg;
    logic                 in_progress;
    logic                 advance;
    logic                 clear;

    modport ctl (
        output offset_mode,
        output seg_offset,
        output seg_count,
        output advance,
        output clear,
        input  offset_ok,
        input  last_seg,
        input  in_progress
    );

    modport trk (
        input  offset_mode,
        input  seg_offset,
        input  seg_count,
        input  advance,
        input  clear,
        output offset_ok,
        output last_seg,
        output in_progress
    );
endinterface : fwd_seg_if

`default_nettype wire

/* File: core/fwd_seg_track.sv */
// segment order tracker for offset-mode downloads
`timescale 1ns/100ps
`default_nettype none

module fwd_seg_track #(
    parameter logic [15:0] IMG_SECTORS = 16'h0040
) (
    input  wire logic core_clk,
    input  wire logic reset_n,
    input  wire logic clk_en,
    fwd_seg_if.trk    seg
);
    fwd_pkg::fwd_sectors_t expected;
    logic [16:0]           seg_end;

    assign seg_end = {1'b0, seg.seg_offset} + {1'b0, seg.seg_count};

    // first segment must land at zero since expected starts there
    assign seg.offset_ok   = !seg.offset_mode ||
                             (seg.seg_offset == expected);
    // whole-image command is its own last segment
    assign seg.last_seg    = !seg.offset_mode ||
                             (seg_end >= {1'b0, IMG_SECTORS});
    assign seg.in_progress = (expected != 16'h0000);

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            expected <= 16'h0000;
        end else if (clk_en) begin
            if (seg.clear) begin
                expected <= 16'h0000;
            end else if (seg.advance) begin
                expected <= seg_end[15:0];
            end
        end
    end
endmodule : fwd_seg_track

`default_nettype wire

/* File: core/fwd_image_store.sv */
// microcode image buffer with a single held-image flag
`timescale 1ns/100ps
`default_nettype none

module fwd_image_store #(
    parameter int ADDR_W = 14
) (
    input  wire logic              core_clk,
    input  wire logic              reset_n,
    input  wire logic              clk_en,
    input  wire logic              wr_en,
    input  wire logic [ADDR_W-1:0] wr_addr,
    input  wire logic [15:0]       wr_data,
    input  wire logic              discard,
    input  wire logic [ADDR_W-1:0] rd_addr,
    output logic [15:0]            rd_data,
    output logic                   image_held
);
    logic [15:0] mem [0:(1<<ADDR_W)-1];

    // contents are not wiped on discard; image_held gates their use
    always_ff @(posedge core_clk) begin
        if (clk_en && wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_data <= 16'h0000;
        end else if (clk_en) begin
            rd_data <= mem[rd_addr];
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            image_held <= 1'b0;
        end else if (clk_en) begin
            if (wr_en) begin
                image_held <= 1'b1;
            end else if (discard) begin
                image_held <= 1'b0;
            end
        end
    end
endmodule : fwd_image_store

`default_nettype wire

/* File: core/fwd_download_cmd.sv */
// firmware download command interpreter, device side
`timescale 1ns/100ps
`default_nettype none
`include "fwd_consts.svh"

module fwd_download_cmd #(
    parameter logic [15:0] IMG_SECTORS = 16'h0040,
    parameter int          ADDR_W      = 14
) (
    input  wire logic              core_clk,
    input  wire logic              reset_n,
    input  wire logic              clk_en,
    input  wire logic              soft_reset,
    input  wire logic              reg_wr_en,
    input  wire logic [2:0]        reg_wr_addr,
    input  wire logic [7:0]        reg_wr_data,
    input  wire logic              reg_rd_en,
    input  wire logic [2:0]        reg_rd_addr,
    output logic [7:0]             reg_rd_data,
    input  wire logic              data_valid,
    input  wire logic [15:0]       data_word,
    output logic                   data_ready,
    input  wire logic              security_locked,
    input  wire logic              spinup_disabled,
    output logic                   verify_start,
    input  wire logic              verify_done,
    input  wire logic              verify_pass,
    input  wire logic              reload_requested,
    input  wire logic              reload_ok,
    output logic                   save_start,
    output logic                   fw_activate,
    output logic                   spin_down,
    output logic                   image_discard,
    output logic                   foreign_cmd_valid,
    output logic [7:0]             foreign_cmd_code,
    input  wire logic [ADDR_W-1:0] fw_rd_addr,
    output logic [15:0]            fw_rd_data,
    output logic                   fw_image_held
);
    fwd_pkg::fwd_state_e   state;
    fwd_pkg::fwd_state_e   next_state;

    logic [7:0]            subcommand_select;
    logic [7:0]            length_low_byte;
    logic [7:0]            length_high_byte;
    logic [7:0]            image_offset_low;
    logic [7:0]            image_offset_high;
    logic [7:0]            drive_select;
    logic [7:0]            failure_flags;
    logic [7:0]            drive_condition;

    fwd_pkg::fwd_sectors_t seg_len;
    fwd_pkg::fwd_sectors_t seg_off;
    logic [23:0]           words_left;
    logic [23:0]           word_idx;
    logic [ADDR_W-1:0]     store_addr;
    logic [ADDR_W-1:0]     base_addr;
    logic                  opcode_wr;
    logic                  is_download;
    logic                  sub_valid;
    logic                  offset_mode;
    logic                  seg_last;
    logic                  word_take;
    logic                  discard_now;
    logic                  cmd_abort;
    logic                  load_fail;

    fwd_seg_if seg ();

    assign opcode_wr   = reg_wr_en && (reg_wr_addr == `FWD_REG_OPCODE);
    assign is_download = (reg_wr_data == `FWD_OP_DOWNLOAD);
    assign offset_mode = (subcommand_select == `FWD_SUB_OFFSET);
    assign sub_valid   = offset_mode ||
                         (subcommand_select == `FWD_SUB_WHOLE);
    // length: high byte first
    assign seg_len     = {length_high_byte, length_low_byte};
    // offset registers ignored for the whole-image form
    assign seg_off     = offset_mode ?
                         {image_offset_high, image_offset_low} :
                         16'h0000;
    assign word_take   = (state == fwd_pkg::FWD_XFER) && data_ready &&
                         data_valid;
    // image address: offset in 512-byte sectors, 256 words each
    assign base_addr   = ADDR_W'({seg_off, 8'h00});
    assign store_addr  = base_addr + ADDR_W'(word_idx);

    assign seg.offset_mode = offset_mode;
    assign seg.seg_offset  = seg_off;
    assign seg.seg_count   = seg_len;

    // soft reset, other command write while a download is partial or running, or offset mismatch
    assign discard_now =
        soft_reset ||
        (opcode_wr && !is_download &&
         (seg.in_progress || state != fwd_pkg::FWD_IDLE)) ||
        (state == fwd_pkg::FWD_CHECK && sub_valid &&
         !security_locked && !seg.offset_ok);

    assign seg.clear   = discard_now ||
                         (state == fwd_pkg::FWD_VERIFY && verify_done);
    assign seg.advance = (state == fwd_pkg::FWD_XFER && words_left == 24'h1
                          && word_take && !seg_last) ||
                         (state == fwd_pkg::FWD_CHECK && sub_valid &&
                          !security_locked && seg.offset_ok &&
                          seg_len == 16'h0000 && !seg.last_seg);

    fwd_seg_track #(
        .IMG_SECTORS (IMG_SECTORS)
    ) u_seg_track (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .clk_en   (clk_en),
        .seg      (seg)
    );

    fwd_image_store #(
        .ADDR_W (ADDR_W)
    ) u_image_store (
        .core_clk   (core_clk),
        .reset_n    (reset_n),
        .clk_en     (clk_en),
        .wr_en      (word_take),
        .wr_addr    (store_addr),
        .wr_data    (data_word),
        .discard    (discard_now),
        .rd_addr    (fw_rd_addr),
        .rd_data    (fw_rd_data),
        .image_held (fw_image_held)
    );

    // host-written command block registers
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            subcommand_select <= `FWD_BYTE_ZERO;
            length_low_byte   <= `FWD_BYTE_ZERO;
            length_high_byte  <= `FWD_BYTE_ZERO;
            image_offset_low  <= `FWD_BYTE_ZERO;
            image_offset_high <= `FWD_BYTE_ZERO;
            drive_select      <= `FWD_BYTE_ZERO;
        end else if (clk_en && reg_wr_en &&
                     state == fwd_pkg::FWD_IDLE) begin
            unique case (reg_wr_addr)
                `FWD_REG_SUBCMD: subcommand_select <= reg_wr_data;
                `FWD_REG_LEN_LO: length_low_byte   <= reg_wr_data;
                `FWD_REG_LEN_HI: length_high_byte  <= reg_wr_data;
                `FWD_REG_OFF_LO: image_offset_low  <= reg_wr_data;
                `FWD_REG_OFF_HI: image_offset_high <= reg_wr_data;
                `FWD_REG_DRIVE:  drive_select      <= reg_wr_data;
                default: ;
            endcase
        end
    end

    // command sequencing
    always_comb begin
        next_state = state;
        unique case (state)
            fwd_pkg::FWD_IDLE: begin
                if (opcode_wr && is_download) begin
                    next_state = fwd_pkg::FWD_CHECK;
                end
            end
            fwd_pkg::FWD_CHECK: begin
                if (!sub_valid || security_locked) begin
                    next_state = fwd_pkg::FWD_ABORT;
                end else if (!seg.offset_ok) begin
                    next_state = fwd_pkg::FWD_ABORT;
                end else if (seg_len == 16'h0000) begin
                    next_state = fwd_pkg::FWD_FINISH;
                end else begin
                    next_state = fwd_pkg::FWD_XFER;
                end
            end
            fwd_pkg::FWD_XFER: begin
                if (word_take && words_left == 24'h1) begin
                    next_state = seg_last ? fwd_pkg::FWD_VERIFY :
                                            fwd_pkg::FWD_FINISH;
                end
            end
            fwd_pkg::FWD_VERIFY: begin
                if (verify_done) begin
                    next_state = fwd_pkg::FWD_FINISH;
                end
            end
            fwd_pkg::FWD_FINISH: next_state = fwd_pkg::FWD_IDLE;
            fwd_pkg::FWD_ABORT:  next_state = fwd_pkg::FWD_IDLE;
        endcase
        if (discard_now && state != fwd_pkg::FWD_CHECK) begin
            next_state = fwd_pkg::FWD_IDLE;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= fwd_pkg::FWD_IDLE;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    // latch the last-segment decision when the data phase opens
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            seg_last <= 1'b0;
        end else if (clk_en && state == fwd_pkg::FWD_CHECK) begin
            seg_last <= seg.last_seg;
        end
    end

    // whole sectors only: length is counted in 256-word units
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            words_left <= 24'h00_0000;
            word_idx   <= 24'h00_0000;
        end else if (clk_en) begin
            if (state == fwd_pkg::FWD_CHECK) begin
                words_left <= {seg_len, 8'h00};
                word_idx   <= 24'h00_0000;
            end else if (word_take) begin
                words_left <= words_left - 24'h00_0001;
                word_idx   <= word_idx + 24'h00_0001;
            end
        end
    end

    // ready falls on the edge that takes the last word, so it is taken exactly once
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            data_ready <= 1'b0;
        end else if (clk_en) begin
            data_ready <= (next_state == fwd_pkg::FWD_XFER) &&
                          !(word_take && words_left == 24'h1);
        end
    end

    assign cmd_abort = (state == fwd_pkg::FWD_CHECK &&
                        next_state == fwd_pkg::FWD_ABORT) ||
                       (state == fwd_pkg::FWD_VERIFY && verify_done &&
                        !verify_pass);
    assign load_fail = state == fwd_pkg::FWD_VERIFY && verify_done &&
                       verify_pass && reload_requested && !reload_ok;

    // error register: fresh per download command
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            failure_flags <= `FWD_BYTE_ZERO;
        end else if (clk_en) begin
            if (state == fwd_pkg::FWD_IDLE && opcode_wr && is_download) begin
                failure_flags <= `FWD_BYTE_ZERO;
            end else begin
                if (cmd_abort) begin
                    failure_flags[`FWD_ERR_ABORT_BIT] <= 1'b1;
                end
                if (load_fail) begin
                    failure_flags[`FWD_ERR_UNCORR_BIT] <= 1'b1;
                end
            end
        end
    end

    // status: busy while checking or verifying, drq in data phase
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            drive_condition <= `FWD_STATUS_RESET;
        end else if (clk_en) begin
            drive_condition <= `FWD_STATUS_RESET;
            drive_condition[`FWD_ST_BSY_BIT] <=
                next_state == fwd_pkg::FWD_CHECK ||
                next_state == fwd_pkg::FWD_VERIFY;
            drive_condition[`FWD_ST_DRQ_BIT] <=
                next_state == fwd_pkg::FWD_XFER;
            if (cmd_abort || load_fail) begin
                drive_condition[`FWD_ST_ERR_BIT] <= 1'b1;
            end else begin
                // error stands until the next download opcode
                drive_condition[`FWD_ST_ERR_BIT] <=
                    drive_condition[`FWD_ST_ERR_BIT] &&
                    !(opcode_wr && is_download);
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rd_data <= `FWD_BYTE_ZERO;
        end else if (clk_en && reg_rd_en) begin
            unique case (reg_rd_addr)
                `FWD_REG_SUBCMD: reg_rd_data <= failure_flags;
                `FWD_REG_OPCODE: reg_rd_data <= drive_condition;
                default:         reg_rd_data <= `FWD_BYTE_ZERO;
            endcase
        end
    end

    // one-cycle event pulses toward drive firmware
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            verify_start  <= 1'b0;
            save_start    <= 1'b0;
            fw_activate   <= 1'b0;
            spin_down     <= 1'b0;
            image_discard <= 1'b0;
        end else if (clk_en) begin
            verify_start  <= state == fwd_pkg::FWD_XFER &&
                             next_state == fwd_pkg::FWD_VERIFY;
            // save only after a passing verification
            save_start    <= state == fwd_pkg::FWD_VERIFY &&
                             verify_done && verify_pass;
            fw_activate   <= state == fwd_pkg::FWD_VERIFY &&
                             verify_done && verify_pass &&
                             (!reload_requested || reload_ok);
            spin_down     <= state == fwd_pkg::FWD_VERIFY &&
                             verify_done && verify_pass &&
                             reload_requested && reload_ok &&
                             spinup_disabled;
            image_discard <= discard_now ||
                             (state == fwd_pkg::FWD_VERIFY &&
                              verify_done && !verify_pass);
        end
    end

    // other commands still run; they are handed on untouched
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            foreign_cmd_valid <= 1'b0;
            foreign_cmd_code  <= `FWD_BYTE_ZERO;
        end else if (clk_en) begin
            foreign_cmd_valid <= opcode_wr && !is_download;
            if (opcode_wr && !is_download) begin
                foreign_cmd_code <= reg_wr_data;
            end
        end
    end
endmodule : fwd_download_cmd

`default_nettype wire

/* File: verification/fwd_download_monitor.sv */
// assertion checker for the firmware download command block
`timescale 1ns/100ps
`default_nettype none

module fwd_download_monitor (
    input wire logic       core_clk,
    input wire logic       reset_n,
    input wire logic       clk_en,
    input wire logic       soft_reset,
    input wire logic       reg_wr_en,
    input wire logic [2:0] reg_wr_addr,
    input wire logic [7:0] reg_wr_data,
    input wire logic       data_valid,
    input wire logic       data_ready,
    input wire logic       security_locked,
    input wire logic       spinup_disabled,
    input wire logic       verify_done,
    input wire logic       verify_pass,
    input wire logic       reload_requested,
    input wire logic       reload_ok,
    input wire logic       save_start,
    input wire logic       fw_activate,
    input wire logic       spin_down,
    input wire logic       image_discard,
    input wire logic       foreign_cmd_valid,
    input wire logic       fw_image_held
);
    logic [7:0]  sub_q;
    logic [15:0] len_q;
    logic [23:0] taken;
    logic        op_wr;
    logic        dl_wr;
    assign op_wr = reg_wr_en && clk_en && reg_wr_addr == 3'h7;
    assign dl_wr = op_wr && reg_wr_data == 8'h92;
    // shadows of what the host last wrote
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sub_q <= 8'h00;
            len_q <= 16'h0000;
        end else if (reg_wr_en && clk_en) begin
            case (reg_wr_addr)
                3'h1: sub_q <= reg_wr_data;
                3'h2: len_q[7:0] <= reg_wr_data;
                3'h3: len_q[15:8] <= reg_wr_data;
                default: ;
            endcase
        end
    end
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) taken <= 24'h00_0000;
        else if (op_wr) taken <= 24'h00_0000;
        else if (clk_en && data_valid && data_ready) taken <= taken + 24'h1;
    end
    default clocking dc @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    bad_sub_a: assert property (dl_wr && sub_q != 8'h03 &&
        sub_q != 8'h07 |=> !data_ready [*4]) else $error("bad subcommand");
    locked_abort_a: assert property (dl_wr && security_locked |=>
        !data_ready [*4]) else $error("locked drive took data");
    zero_len_a: assert property (dl_wr && len_q == 16'h0000 |=>
        !data_ready [*4]) else $error("zero length took data");
    whole_start_a: assert property (dl_wr && sub_q == 8'h07 &&
        !security_locked && len_q != 16'h0000 |-> ##[1:3] data_ready)
        else $error("data phase missing");
    sector_count_a: assert property ($fell(data_ready) |->
        taken == {len_q, 8'h00}) else $error("word count wrong");
    save_after_a: assert property (verify_done && verify_pass &&
        !reload_requested |=> save_start && fw_activate) else $error("no save");
    reload_fail_a: assert property (verify_done && reload_requested &&
        !reload_ok |=> !fw_activate [*2]) else $error("bad reload activated");
    spin_down_a: assert property (verify_done && verify_pass &&
        reload_ok && reload_requested && spinup_disabled |=> spin_down)
        else $error("no spin down");
    soft_discard_a: assert property (soft_reset && fw_image_held |->
        ##[1:2] image_discard) else $error("partial image kept");
    foreign_fwd_a: assert property (op_wr && reg_wr_data != 8'h92 |->
        ##[1:2] foreign_cmd_valid) else $error("command not forwarded");
    cover property (save_start);
    cover property (image_discard);
    cover property (foreign_cmd_valid);
endmodule // fwd_download_monitor

bind fwd_download_cmd fwd_download_monitor fwd_download_monitor_i (.*);

`default_nettype wire

/* File: verification/fwd_host_model.sv */
// host controller model streaming microcode words
`timescale 1ns/100ps
`default_nettype none

module fwd_host_model (
    input wire logic  core_clk,
    input wire logic  reset_n,
    input wire logic  data_ready,
    output var logic  data_valid,
    output var logic [15:0] data_word
);
    logic [15:0] cnt;
    logic [2:0]  ph;
    // offers words without end; the device's whole-sector count decides how many are taken
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt <= 16'h0000;
            ph <= 3'h0;
            data_valid <= 1'b0;
        end else begin
            ph <= ph + 3'h1;
            if (data_valid && data_ready) cnt <= cnt + 16'h0001;
            // a taken word may be followed by a stall, never a retracted one
            if (!data_valid) data_valid <= 1'b1;
            else if (data_ready && ph == 3'h7) data_valid <= 1'b0;
        end
    end
    assign data_word = data_valid ? cnt : ~cnt;
endmodule // fwd_host_model

`default_nettype wire

/* File: verification/testbench.sv */
// self-checking testbench for the firmware download command block
`timescale 1ns/100ps
`default_nettype none

module testbench;
    logic core_clk = 0, reset_n = 0, clk_en = 1, soft_reset = 0, clr = 0;
    logic reg_wr_en = 0, reg_rd_en = 0, security_locked = 0;
    logic spinup_disabled = 0, verify_done = 0, verify_pass = 0;
    logic reload_requested = 0, reload_ok = 0, data_valid, data_ready;
    logic verify_start, save_start, fw_activate, spin_down, image_discard;
    logic foreign_cmd_valid, fw_image_held;
    logic [2:0]  reg_wr_addr = 0, reg_rd_addr = 0;
    logic [7:0]  reg_wr_data = 0, reg_rd_data, foreign_cmd_code;
    logic [15:0] data_word, fw_rd_data;
    logic [9:0]  fw_rd_addr = 0;
    logic [5:0]  seen;
    logic [7:0]  v;
    int          error_cnt = 0, n_compared = 0;

    fwd_download_cmd #(.IMG_SECTORS(16'h0002), .ADDR_W(10))
        fwd_download_cmd_i (.*);
    fwd_host_model fwd_host_model_i (.core_clk(core_clk), .reset_n(reset_n),
        .data_ready(data_ready), .data_valid(data_valid),
        .data_word(data_word));

    initial forever #2 core_clk = ~core_clk;
    // verify engine answers one cycle after each request
    always @(posedge core_clk) verify_done <= verify_start;
    always @(posedge core_clk)
        seen <= clr ? 6'h00 : seen | {foreign_cmd_valid, image_discard,
            spin_down, fw_activate, save_start, verify_start};

    task automatic report_and_stop;
        $display("errors %0d compared %0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr_en <= 1;
        reg_wr_addr <= a;
        reg_wr_data <= d;
        @(posedge core_clk);
        reg_wr_en <= 0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_rd_en <= 1;
        reg_rd_addr <= a;
        @(posedge core_clk);
        reg_rd_en <= 0;
        #1 d = reg_rd_data;
    endtask
    // ctl: soft reset, locked, spin-up off, pass, reload, reload ok
    task automatic run(input logic [7:0] sub, input logic [15:0] len, off,
        input logic [7:0] op, input logic [5:0] ctl,
        input logic [7:0] e_err, e_st, input logic [5:0] e_seen);
        logic [7:0] s;
        int         i;
        @(posedge core_clk);
        clr <= 1;
        soft_reset <= ctl[5];
        {security_locked, spinup_disabled} <= ctl[4:3];
        {verify_pass, reload_requested, reload_ok} <= ctl[2:0];
        @(posedge core_clk);
        clr <= 0;
        soft_reset <= 0;
        wr(3'h1, sub);
        wr(3'h2, len[7:0]);
        wr(3'h3, len[15:8]);
        wr(3'h4, off[7:0]);
        wr(3'h5, off[15:8]);
        wr(3'h7, op);
        for (i = 0; i < 3000; i++) begin
            rd(3'h7, s);
            if ((s & 8'h88) == 8'h00) break;
        end
        if (i == 3000) begin
            error_cnt++;
            report_and_stop();
        end
        rd(3'h1, s);
        chk(s, e_err);
        chk(reg_rd_data, e_err);
        rd(3'h7, s);
        chk(s, e_st);
        chk({2'b00, seen}, {2'b00, e_seen});
    endtask

    initial begin
        repeat (6) @(posedge core_clk);
        reset_n <= 1;
        rd(3'h7, v);
        chk(v, 8'h50);
        rd(3'h3, v);
        chk(v, 8'h00);
        run(8'h05, 16'h1, 16'h0, 8'h92, 6'h04, 8'h04, 8'h51, 6'h00);
        run(8'h07, 16'h2, 16'h0, 8'h92, 6'h14, 8'h04, 8'h51, 6'h00);
        run(8'h07, 16'h0, 16'h0, 8'h92, 6'h04, 8'h00, 8'h50, 6'h00);
        run(8'h07, 16'h2, 16'h9, 8'h92, 6'h04, 8'h00, 8'h50, 6'h07);
        run(8'h03, 16'h1, 16'h0, 8'h92, 6'h04, 8'h00, 8'h50, 6'h00);
        run(8'h03, 16'h1, 16'h1, 8'h92, 6'h04, 8'h00, 8'h50, 6'h07);
        run(8'h03, 16'h1, 16'h0, 8'h92, 6'h04, 8'h00, 8'h50, 6'h00);
        run(8'h03, 16'h1, 16'h5, 8'h92, 6'h04, 8'h04, 8'h51, 6'h10);
        run(8'h03, 16'h1, 16'h0, 8'h92, 6'h04, 8'h00, 8'h50, 6'h00);
        run(8'h00, 16'h0, 16'h0, 8'hE7, 6'h04, 8'h00, 8'h50, 6'h30);
        run(8'h03, 16'h1, 16'h0, 8'h92, 6'h04, 8'h00, 8'h50, 6'h00);
        run(8'h03, 16'h1, 16'h1, 8'h92, 6'h24, 8'h04, 8'h51, 6'h10);
        run(8'h07, 16'h2, 16'h0, 8'h92, 6'h06, 8'h40, 8'h51, 6'h03);
        run(8'h07, 16'h2, 16'h0, 8'h92, 6'h0F, 8'h00, 8'h50, 6'h0F);
        run(8'h07, 16'h2, 16'h0, 8'h92, 6'h00, 8'h04, 8'h51, 6'h11);
        chk(foreign_cmd_code, 8'hE7);
        chk(fw_rd_data[15:8], 8'h0B);
        report_and_stop();
    end
endmodule // testbench

`default_nettype wire
